/* File: verilog/ivp_pkg.sv */
package ivp_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] MCU_CONTROL_ADDR = 8'h35;
  localparam logic [7:0] MCU_CONTROL_RST  = 8'h00;

  // ---------------------------------------------------------------
  // Field positions inside mcu_control
  // ---------------------------------------------------------------
  localparam int UNLOCK_BIT       = 0;
  localparam int VSEL_BIT         = 1;
  localparam int PULLUP_OFF_BIT   = 4;
  localparam int BOD_UNLOCK_BIT   = 5;
  localparam int BOD_SLEEP_BIT    = 6;
  localparam int DEBUG_OFF_BIT    = 7;
  localparam logic [7:0] STORED_MASK = 8'hf0;

  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  // ---------------------------------------------------------------
  // Flash geometry, word addresses
  // ---------------------------------------------------------------
  localparam int          PC_W           = 17;
  localparam logic [17:0] FLASH_END      = 18'h20000;
  localparam logic [16:0] BOOT_WORDS_SZ0 = 17'h01000;
  localparam logic [16:0] BOOT_WORDS_SZ1 = 17'h00800;
  localparam logic [16:0] BOOT_WORDS_SZ2 = 17'h00400;
  localparam logic [16:0] BOOT_WORDS_SZ3 = 17'h00200;
  localparam logic [16:0] APP_BASE       = 17'h00000;
  localparam logic [5:0]  SLOT_EXT_IRQ0  = 6'h01;
  localparam logic [5:0]  SLOT_EXT_IRQ1  = 6'h02;
  localparam logic [5:0]  SLOT_SELFPROG  = 6'h1b;

  // ---------------------------------------------------------------
  // Static input bundle, reset values (unprogrammed)
  // ---------------------------------------------------------------
  localparam int         STRAP_W   = 5;
  localparam logic [4:0] STRAP_RST = 5'h00;

  // ---------------------------------------------------------------
  // Change sequence states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IVP_IDLE   = 2'b00,
    IVP_UNLOCK = 2'b01,
    IVP_HOLD   = 2'b10
  } ivp_state_t;

endpackage : ivp_pkg

/* File: verilog/ivp_vector_place.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
// Summary of operation
// RL1: Vector select zero puts the vector table at flash start.
// RL2: Vector select one moves the vector table to boot section start.
// RL3: Boot section start, and relocated base, follow the boot size fuses.
// RL4: Software sets unlock, then within four cycles writes select with unlock zero.
// RL5: Dispatch masked from unlock write until after instruction following select write.
// RL6: Without a select write, dispatch stays masked four cycles only.
// RL7: Automatic masking never alters the global interrupt enable flag.
// RL8: Unlock clears itself after four cycles or when select is written.
// RL9: Boot vectors plus app-side lock block interrupts while running application code.
// RL10: App vectors plus boot-side lock block interrupts while running boot code.
// RL11: Relocated with 8K boot and reset-to-boot fuse: reset 0x1F000, IRQ0 0x1F002, IRQ1 0x1F004.
// RL12: Reset-to-boot fuse, not relocated: start at 0x1F000, IRQ0 at 0x00002.
// RL13: Self-programming-ready vector is last: 0x00036, or 0x1F036 relocated.
// RL14: Fuse unprogrammed, relocated: reset at 0x00000, IRQ0 at 0x1F002.
// RL15: Select write without a live unlock leaves placement unchanged.
module ivp_vector_place #(
  parameter int ADDR_W = 8,
  parameter int SLOT_W = 6
) (
  // Clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_b_in,
  // Register port
  input  wire logic [ADDR_W-1:0]       reg_addr_in,
  input  wire logic [7:0]              reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [7:0]              reg_rdata_out,
  // Fuses and lock bits, high means programmed
  input  wire logic [1:0]              boot_size_fuses_in,
  input  wire logic                    reset_to_boot_fuse_in,
  input  wire logic                    app_side_boot_lock_in,
  input  wire logic                    boot_side_boot_lock_in,
  // Core side
  input  wire logic [ivp_pkg::PC_W-1:0] exec_pc_in,
  input  wire logic                    instr_retire_in,
  input  wire logic                    global_irq_enable_in,
  input  wire logic [SLOT_W-1:0]       irq_slot_in,
  output logic      [ivp_pkg::PC_W-1:0] vector_base_out,
  output logic      [ivp_pkg::PC_W-1:0] reset_vector_out,
  output logic      [ivp_pkg::PC_W-1:0] irq_vector_out,
  output logic      [ivp_pkg::PC_W-1:0] selfprog_ready_vector_out,
  output logic                         irq_dispatch_mask_out,
  output logic                         irq_dispatch_enable_out,
  // Other control bits, stored only
  output logic                         debug_port_disable_out,
  output logic                         brownout_sleep_off_out,
  output logic                         brownout_sleep_unlock_out,
  output logic                         pullup_global_off_out
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (ADDR_W < 6) begin
      $error("ivp_vector_place: ADDR_W too small for register offset");
    end
    if (SLOT_W < 6 || SLOT_W > 10) begin
      $error("ivp_vector_place: SLOT_W must lie between 6 and 10");
    end
    // Package values the logic below relies on
    if (ivp_pkg::UNLOCK_CYCLES == 3'h0) begin
      $error("ivp_vector_place: unlock window must last at least one cycle");
    end
    if (ivp_pkg::UNLOCK_BIT == ivp_pkg::VSEL_BIT) begin
      $error("ivp_vector_place: unlock and select bits must differ");
    end
    if (ivp_pkg::MCU_CONTROL_RST[ivp_pkg::UNLOCK_BIT] != 1'b0) begin
      $error("ivp_vector_place: unlock must reset to zero, the sequence resets idle");
    end
    if (ivp_pkg::STORED_MASK != 8'hf0) begin
      $error("ivp_vector_place: stored bits are kept as the upper nibble only");
    end
    if (ivp_pkg::PULLUP_OFF_BIT < 4 || ivp_pkg::DEBUG_OFF_BIT > 7) begin
      $error("ivp_vector_place: stored control bits must sit in bits 7 to 4");
    end
    if (ivp_pkg::BOOT_WORDS_SZ0 == 17'h00000 || ivp_pkg::BOOT_WORDS_SZ3 == 17'h00000) begin
      $error("ivp_vector_place: boot section size must not be zero");
    end
    if (ivp_pkg::FLASH_END > (18'h00001 << ivp_pkg::PC_W)) begin
      $error("ivp_vector_place: flash end does not fit the program counter");
    end
    if ({1'b0, ivp_pkg::BOOT_WORDS_SZ0} >= ivp_pkg::FLASH_END) begin
      $error("ivp_vector_place: largest boot section must leave application space");
    end
    if ({ivp_pkg::SLOT_SELFPROG, 1'b0} >= ivp_pkg::BOOT_WORDS_SZ3) begin
      $error("ivp_vector_place: vector table must fit the smallest boot section");
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [ivp_pkg::PC_W-1:0] boot_start(input logic [1:0] sz);
    logic [16:0] words;
    words = ivp_pkg::BOOT_WORDS_SZ0;
    case (sz)
      2'b00:   words = ivp_pkg::BOOT_WORDS_SZ0;
      2'b01:   words = ivp_pkg::BOOT_WORDS_SZ1;
      2'b10:   words = ivp_pkg::BOOT_WORDS_SZ2;
      default: words = ivp_pkg::BOOT_WORDS_SZ3;
    endcase
    boot_start = 17'(ivp_pkg::FLASH_END - {1'b0, words});
  endfunction : boot_start

  // Two words per slot, so slot n sits at base + 2n
  function automatic logic [ivp_pkg::PC_W-1:0] slot_addr(input logic [ivp_pkg::PC_W-1:0] base,
                                                         input logic [SLOT_W-1:0]         slot);
    slot_addr = 17'(base + {6'h00, 10'(slot), 1'b0});
  endfunction : slot_addr

  // ---------------------------------------------------------------
  // Static input filter
  // ---------------------------------------------------------------
  // Straps are static, yet they come from outside; a value only counts once
  // the second and third stages agree, so a glitch never reaches vectors.
  logic [ivp_pkg::STRAP_W-1:0] strap_raw;
  logic [ivp_pkg::STRAP_W-1:0] strap_s1_reg;
  logic [ivp_pkg::STRAP_W-1:0] strap_s2_reg;
  logic [ivp_pkg::STRAP_W-1:0] strap_s3_reg;
  logic [ivp_pkg::STRAP_W-1:0] strap_reg;
  logic [ivp_pkg::STRAP_W-1:0] strap_s1_next;
  logic [ivp_pkg::STRAP_W-1:0] strap_s2_next;
  logic [ivp_pkg::STRAP_W-1:0] strap_s3_next;
  logic [ivp_pkg::STRAP_W-1:0] strap_next;

  assign strap_raw = {boot_side_boot_lock_in, app_side_boot_lock_in,
                      reset_to_boot_fuse_in, boot_size_fuses_in};

  always_comb begin
    strap_s1_next = strap_raw;
    strap_s2_next = strap_s1_reg;
    strap_s3_next = strap_s2_reg;
    strap_next    = (strap_s2_reg & strap_s3_reg) | (strap_reg & (strap_s2_reg | strap_s3_reg));
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_s1_reg <= ivp_pkg::STRAP_RST;
      strap_s2_reg <= ivp_pkg::STRAP_RST;
      strap_s3_reg <= ivp_pkg::STRAP_RST;
      strap_reg    <= ivp_pkg::STRAP_RST;
    end else begin
      strap_s1_reg <= strap_s1_next;
      strap_s2_reg <= strap_s2_next;
      strap_s3_reg <= strap_s3_next;
      strap_reg    <= strap_next;
    end
  end

  logic [1:0] boot_size;
  logic       boot_reset_fuse;
  logic       app_lock;
  logic       boot_lock;

  assign boot_size       = strap_reg[1:0];
  assign boot_reset_fuse = strap_reg[2];
  assign app_lock        = strap_reg[3];
  assign boot_lock       = strap_reg[4];

  // ---------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------
  logic ctl_hit;
  logic ctl_wr;
  logic ctl_rd;
  logic wr_unlock;
  logic wr_vsel_val;

  assign ctl_hit     = (reg_addr_in == ADDR_W'(ivp_pkg::MCU_CONTROL_ADDR));
  assign ctl_wr      = reg_wr_in & ctl_hit;
  assign ctl_rd      = reg_rd_in & ctl_hit;
  assign wr_unlock   = reg_wdata_in[ivp_pkg::UNLOCK_BIT];
  assign wr_vsel_val = reg_wdata_in[ivp_pkg::VSEL_BIT];

  // ---------------------------------------------------------------
  // Change sequence
  // ---------------------------------------------------------------
  ivp_pkg::ivp_state_t state_reg;
  ivp_pkg::ivp_state_t state_next;
  logic [2:0]          unlock_cnt_reg;
  logic [2:0]          unlock_cnt_next;
  logic                vsel_reg;
  logic                vsel_next;
  logic [3:0]          stored_reg;
  logic [3:0]          stored_next;

  always_comb begin
    state_next      = state_reg;
    unlock_cnt_next = unlock_cnt_reg;
    vsel_next       = vsel_reg;
    stored_next     = stored_reg;
    if (ctl_wr) begin
      stored_next = reg_wdata_in[7:4];
    end
    case (state_reg)
      ivp_pkg::IVP_IDLE: begin
        if (ctl_wr && wr_unlock) begin
          state_next      = ivp_pkg::IVP_UNLOCK;                         // RL4
          unlock_cnt_next = ivp_pkg::UNLOCK_CYCLES;
        end
        // A select write here has no unlock behind it and is dropped
        // Stored bits still land, so a plain write never moves the table // RL15
      end
      ivp_pkg::IVP_UNLOCK: begin
        if (ctl_wr && !wr_unlock) begin
          vsel_next       = wr_vsel_val;                                 // RL4
          state_next      = ivp_pkg::IVP_HOLD;                           // RL8
          unlock_cnt_next = 3'h0;
        end else if (ctl_wr && wr_unlock) begin
          // Rewriting the unlock restarts the window
          unlock_cnt_next = ivp_pkg::UNLOCK_CYCLES;
        end else if (unlock_cnt_reg <= 3'h1) begin
          state_next      = ivp_pkg::IVP_IDLE;                           // RL8
          unlock_cnt_next = 3'h0;
        end else begin
          unlock_cnt_next = unlock_cnt_reg - 3'h1;                       // RL6
        end
      end
      ivp_pkg::IVP_HOLD: begin
        // A fresh unlock here is ignored; the pending close must finish first
        // The select write's own instruction has already retired;
        // the next retire pulse closes the following instruction.
        if (instr_retire_in) begin
          state_next = ivp_pkg::IVP_IDLE;                                // RL5
        end
      end
      default: begin
        state_next      = ivp_pkg::IVP_IDLE;
        unlock_cnt_next = 3'h0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg      <= ivp_pkg::IVP_IDLE;
      unlock_cnt_reg <= 3'h0;
      vsel_reg       <= ivp_pkg::MCU_CONTROL_RST[ivp_pkg::VSEL_BIT];
      stored_reg     <= ivp_pkg::MCU_CONTROL_RST[7:4];
    end else begin
      state_reg      <= state_next;
      unlock_cnt_reg <= unlock_cnt_next;
      vsel_reg       <= vsel_next;
      stored_reg     <= stored_next;
    end
  end

  // ---------------------------------------------------------------
  // Dispatch gating
  // ---------------------------------------------------------------
  logic unlock_write_now;
  logic seq_mask;
  logic in_boot_section;
  logic lock_mask;
  logic [ivp_pkg::PC_W-1:0] boot_base;

  assign boot_base        = boot_start(boot_size);                       // RL3
  assign unlock_write_now = ctl_wr & wr_unlock & (state_reg == ivp_pkg::IVP_IDLE);
  // Masked already in the cycle of the unlock write, not one cycle late
  assign seq_mask         = unlock_write_now | (state_reg != ivp_pkg::IVP_IDLE); // RL5 RL6
  assign in_boot_section  = (exec_pc_in >= boot_base);
  assign lock_mask        = ( vsel_reg && app_lock  && !in_boot_section) ||  // RL9
                            (!vsel_reg && boot_lock &&  in_boot_section);    // RL10

  // Global flag is only read, never written; the mask sits beside it
  assign irq_dispatch_mask_out   = seq_mask | lock_mask;                 // RL7
  assign irq_dispatch_enable_out = global_irq_enable_in & ~irq_dispatch_mask_out; // RL7

  // ---------------------------------------------------------------
  // Vector addresses
  // ---------------------------------------------------------------
  logic [ivp_pkg::PC_W-1:0] vec_base_reg;
  logic [ivp_pkg::PC_W-1:0] vec_base_next;
  logic [ivp_pkg::PC_W-1:0] rst_vec_reg;
  logic [ivp_pkg::PC_W-1:0] rst_vec_next;
  logic [ivp_pkg::PC_W-1:0] irq_vec_reg;
  logic [ivp_pkg::PC_W-1:0] irq_vec_next;
  logic [ivp_pkg::PC_W-1:0] spm_vec_reg;
  logic [ivp_pkg::PC_W-1:0] spm_vec_next;

  always_comb begin
    vec_base_next = vsel_reg ? boot_base : ivp_pkg::APP_BASE;            // RL1 RL2
    // Reset target follows the reset and boot size fuses, not the table placement
    rst_vec_next  = boot_reset_fuse ? boot_base : ivp_pkg::APP_BASE;     // RL11 RL12 RL14
    irq_vec_next  = slot_addr(vec_base_next, irq_slot_in);               // RL11 RL12 RL14
    spm_vec_next  = slot_addr(vec_base_next, SLOT_W'(ivp_pkg::SLOT_SELFPROG)); // RL13
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vec_base_reg <= ivp_pkg::APP_BASE;
      rst_vec_reg  <= ivp_pkg::APP_BASE;
      irq_vec_reg  <= ivp_pkg::APP_BASE;
      spm_vec_reg  <= ivp_pkg::APP_BASE;
    end else begin
      vec_base_reg <= vec_base_next;
      rst_vec_reg  <= rst_vec_next;
      irq_vec_reg  <= irq_vec_next;
      spm_vec_reg  <= spm_vec_next;
    end
  end

  assign vector_base_out           = vec_base_reg;
  assign reset_vector_out          = rst_vec_reg;
  assign irq_vector_out            = irq_vec_reg;
  assign selfprog_ready_vector_out = spm_vec_reg;

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       unlock_live;

  // Bit 0 shows the live window, so software can see it lapse
  assign unlock_live = (state_reg == ivp_pkg::IVP_UNLOCK);

  always_comb begin
    rdata_next = 8'h00;
    if (ctl_rd) begin
      rdata_next                         = {stored_reg, 4'h0};
      rdata_next[ivp_pkg::VSEL_BIT]      = vsel_reg;
      rdata_next[ivp_pkg::UNLOCK_BIT]    = unlock_live;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out             = rdata_reg;
  assign debug_port_disable_out    = stored_reg[ivp_pkg::DEBUG_OFF_BIT - 4];
  assign brownout_sleep_off_out    = stored_reg[ivp_pkg::BOD_SLEEP_BIT - 4];
  assign brownout_sleep_unlock_out = stored_reg[ivp_pkg::BOD_UNLOCK_BIT - 4];
  assign pullup_global_off_out     = stored_reg[ivp_pkg::PULLUP_OFF_BIT - 4];

endmodule : ivp_vector_place

/* File: sim/ivp_checker_sva.sv */
`timescale 1ns/100ps
module ivp_checker #(
  parameter int ADDR_W = 8,
  parameter int SLOT_W = 6
) (
  // Clock, reset and register port
  input wire logic                     core_clk_in,
  input wire logic                     rst_b_in,
  input wire logic [ADDR_W-1:0]        reg_addr_in,
  input wire logic [7:0]               reg_wdata_in,
  input wire logic                     reg_wr_in,
  input wire logic                     reg_rd_in,
  input wire logic [7:0]               reg_rdata_out,
  // Fuses, locks and core side
  input wire logic [1:0]               boot_size_fuses_in,
  input wire logic                     reset_to_boot_fuse_in,
  input wire logic                     app_side_boot_lock_in,
  input wire logic                     boot_side_boot_lock_in,
  input wire logic [ivp_pkg::PC_W-1:0] exec_pc_in,
  input wire logic                     global_irq_enable_in,
  input wire logic [SLOT_W-1:0]        irq_slot_in,
  input wire logic [ivp_pkg::PC_W-1:0] vector_base_out,
  input wire logic [ivp_pkg::PC_W-1:0] reset_vector_out,
  input wire logic [ivp_pkg::PC_W-1:0] irq_vector_out,
  input wire logic                     irq_dispatch_mask_out,
  input wire logic                     irq_dispatch_enable_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ---------------------------------------------------------------
  // Change sequence steps
  // ---------------------------------------------------------------
  sequence unlock_s;
    reg_wr_in && reg_addr_in == 8'h35 && reg_wdata_in[0];
  endsequence
  sequence sel_s;
    reg_wr_in && reg_addr_in == 8'h35 && !reg_wdata_in[0] && boot_size_fuses_in == 2'h0;
  endsequence
  unlock_mask_a: assert property (unlock_s |-> irq_dispatch_mask_out)
    else $error("mask low in unlock write cycle");
  mask_hold_a: assert property (unlock_s ##1 !reg_wr_in [*3] |-> ##1 irq_dispatch_mask_out)
    else $error("mask dropped inside unlock window");
  mask_free_a: assert property (unlock_s ##1 (!reg_wr_in && !app_side_boot_lock_in &&
    !boot_side_boot_lock_in) [*5] |-> !irq_dispatch_mask_out) else $error("mask kept past window");
  unlock_clear_a: assert property (unlock_s ##1 !reg_wr_in [*4] ##1 (reg_rd_in &&
    reg_addr_in == 8'h35) |=> !reg_rdata_out[0]) else $error("unlock bit not cleared");
  sel_commit_a: assert property (unlock_s ##2 sel_s |-> ##2
    vector_base_out == ($past(reg_wdata_in[1], 2) ? 17'h1f000 : 17'h00000)) else $error("base wrong");
  gie_pass_a: assert property (irq_dispatch_enable_out == (global_irq_enable_in && !irq_dispatch_mask_out))
    else $error("enable not gated copy of global flag");
  irq_slot_a: assert property ($stable(vector_base_out) ##1 $stable(vector_base_out) |->
    irq_vector_out == vector_base_out + {$past(irq_slot_in), 1'b0}) else $error("irq vector wrong");
  boot_reset_a: assert property ((reset_to_boot_fuse_in && boot_size_fuses_in == 2'h0) [*8] |->
    reset_vector_out == 17'h1f000) else $error("reset vector not boot start");
  app_lock_a: assert property ((app_side_boot_lock_in && boot_size_fuses_in == 2'h0) [*7] ##0
    (vector_base_out == 17'h1f000 && exec_pc_in < 17'h1f000) |-> irq_dispatch_mask_out)
    else $error("app code not blocked");
  boot_lock_a: assert property ((boot_side_boot_lock_in && boot_size_fuses_in == 2'h0) [*7] ##0
    (vector_base_out == 17'h00000 && exec_pc_in >= 17'h1f000) |-> irq_dispatch_mask_out)
    else $error("boot code not blocked");
endmodule : ivp_checker

bind ivp_vector_place ivp_checker #(.ADDR_W(ADDR_W), .SLOT_W(SLOT_W)) u_chk (.*);

/* File: sim/ivp_core_model.sv */
`timescale 1ns/100ps
module ivp_core_model (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  // Commands from the bench
  input  wire logic [16:0] pc_cmd_in,
  input  wire logic        gie_cmd_in,
  input  wire logic [5:0]  slot_cmd_in,
  input  wire logic        retire_cmd_in,
  // Core pins towards the block
  output logic      [16:0] exec_pc_out,
  output logic             gie_out,
  output logic      [5:0]  slot_out,
  output logic             retire_out
);
  // Global flag moves only on command; the block never writes it
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      exec_pc_out <= 17'h00000;
      gie_out     <= 1'b0;
      slot_out    <= 6'h00;
      retire_out  <= 1'b0;
    end else begin
      exec_pc_out <= pc_cmd_in;
      gie_out     <= gie_cmd_in;
      slot_out    <= slot_cmd_in;
      retire_out  <= retire_cmd_in;
    end
  end
endmodule : ivp_core_model

/* File: sim/interrupt_vector_placement_bench.sv */
`timescale 1ns/100ps
module interrupt_vector_placement_bench;
  typedef struct packed {logic sel; logic [5:0] slot; logic [16:0] irq; logic [16:0] spm;} ivp_row_t;
  logic        core_clk_in, rst_b_in, reg_wr_in, reg_rd_in, instr_retire_in, global_irq_enable_in;
  logic        reset_to_boot_fuse_in, app_side_boot_lock_in, boot_side_boot_lock_in;
  logic        irq_dispatch_mask_out, irq_dispatch_enable_out, ret_c, gie_c, cur;
  logic        debug_port_disable_out, brownout_sleep_off_out, brownout_sleep_unlock_out, pullup_global_off_out;
  logic [1:0]  boot_size_fuses_in;
  logic [5:0]  irq_slot_in, slot_c;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, d;
  logic [16:0] exec_pc_in, pc_c, vector_base_out, reset_vector_out, irq_vector_out, selfprog_ready_vector_out;
  int          failures, cmp_count;
  ivp_row_t    rows [5] = '{'{1'b0, 6'h01, 17'h00002, 17'h00036}, '{1'b0, 6'h02, 17'h00004, 17'h00036},
                            '{1'b1, 6'h01, 17'h1f002, 17'h1f036}, '{1'b1, 6'h02, 17'h1f004, 17'h1f036},
                            '{1'b1, 6'h1b, 17'h1f036, 17'h1f036}};

  ivp_vector_place dut (.*);
  ivp_core_model core (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .pc_cmd_in(pc_c), .gie_cmd_in(gie_c),
    .slot_cmd_in(slot_c), .retire_cmd_in(ret_c), .exec_pc_out(exec_pc_in), .gie_out(global_irq_enable_in),
    .slot_out(irq_slot_in), .retire_out(instr_retire_in));

  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : tick
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    tick(1);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    tick(1);
    reg_wr_in    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    tick(1);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    tick(1);
    reg_rd_in   <= 1'b0;
    @(negedge core_clk_in);
    v = reg_rdata_out;
  endtask : rd_reg
  task automatic retire();
    tick(1);
    ret_c <= 1'b1;
    tick(1);
    ret_c <= 1'b0;
  endtask : retire
  task automatic move(input logic s);
    wr_reg(8'h35, 8'h01);
    wr_reg(8'h35, {6'h00, s, 1'b0});
    retire();
    tick(4);
    cur = s;
  endtask : move
  task automatic mask_is(input logic m);
    @(negedge core_clk_in);
    chk(17'(irq_dispatch_mask_out), 17'(m));
    chk(17'(irq_dispatch_enable_out), 17'(!m));
  endtask : mask_is

  initial begin
    #(50 * 3000);
    failures++;
    results();
  end

  initial begin
    {rst_b_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, ret_c, gie_c, slot_c, pc_c, cur} = '0;
    {boot_size_fuses_in, reset_to_boot_fuse_in, app_side_boot_lock_in, boot_side_boot_lock_in} = '0;
    tick(16);
    rst_b_in <= 1'b1;
    gie_c    <= 1'b1;
    rd_reg(8'h35, d);
    chk(17'(d), 17'h00000);
    // Stored bits, refused select, unmapped place
    wr_reg(8'h36, 8'hff);
    wr_reg(8'h35, 8'hf2);
    rd_reg(8'h35, d);
    chk(17'(d), 17'h000f0);
    rd_reg(8'h36, d);
    chk(17'(d), 17'h00000);
    chk(17'({debug_port_disable_out, brownout_sleep_off_out, brownout_sleep_unlock_out, pullup_global_off_out}),
        17'h0000f);
    chk(vector_base_out, 17'h00000);
    wr_reg(8'h35, 8'h00);
    // Unlock left to lapse
    wr_reg(8'h35, 8'h01);
    fork
      begin
        repeat (4) mask_is(1'b1);
        mask_is(1'b0);
      end
      begin
        tick(1);
        rd_reg(8'h35, d);
        chk(17'(d), 17'h00001);
        rd_reg(8'h35, d);
        chk(17'(d), 17'h00000);
      end
    join
    wr_reg(8'h35, 8'h02);
    tick(4);
    chk(vector_base_out, 17'h00000);
    // Select write holds mask until next retire
    wr_reg(8'h35, 8'h01);
    wr_reg(8'h35, 8'h02);
    repeat (3) mask_is(1'b1);
    retire();
    mask_is(1'b1);
    mask_is(1'b0);
    tick(3);
    cur = 1'b1;
    chk(vector_base_out, 17'h1f000);
    for (int i = 0; i < 5; i++) begin
      if (rows[i].sel !== cur) move(rows[i].sel);
      tick(1);
      slot_c <= rows[i].slot;
      tick(4);
      chk(irq_vector_out, rows[i].irq);
      chk(selfprog_ready_vector_out, rows[i].spm);
      chk(reset_vector_out, 17'h00000);
      chk(vector_base_out, rows[i].sel ? 17'h1f000 : 17'h00000);
    end
    // Reset-to-boot fuse and boot size
    slot_c <= 6'h01;
    reset_to_boot_fuse_in <= 1'b1;
    tick(8);
    chk(reset_vector_out, 17'h1f000);
    chk(irq_vector_out, 17'h1f002);
    boot_size_fuses_in <= 2'h1;
    tick(8);
    chk(vector_base_out, 17'(ivp_pkg::FLASH_END - ivp_pkg::BOOT_WORDS_SZ1));
    boot_size_fuses_in <= 2'h0;
    tick(8);
    move(1'b0);
    chk(reset_vector_out, 17'h1f000);
    chk(irq_vector_out, 17'h00002);
    reset_to_boot_fuse_in <= 1'b0;
    // Boot lock blocking by execution region
    boot_side_boot_lock_in <= 1'b1;
    pc_c <= 17'h1f100;
    tick(8);
    mask_is(1'b1);
    tick(1);
    pc_c <= 17'h00100;
    tick(3);
    mask_is(1'b0);
    tick(1);
    boot_side_boot_lock_in <= 1'b0;
    tick(8);
    move(1'b1);
    app_side_boot_lock_in <= 1'b1;
    tick(8);
    mask_is(1'b1);
    tick(1);
    pc_c <= 17'h1f100;
    tick(3);
    mask_is(1'b0);
    tick(1);
    app_side_boot_lock_in <= 1'b0;
    // Second reset mid-run
    rst_b_in <= 1'b0;
    tick(3);
    rst_b_in <= 1'b1;
    rd_reg(8'h35, d);
    chk(17'(d), 17'h00000);
    chk(vector_base_out, 17'h00000);
    results();
  end
endmodule : interrupt_vector_placement_bench
